// ---- verilog/crtc_vert_pkg.sv ----
package crtc_vert_pkg;

  // ==========================================================
  // register indexes
  localparam logic [7:0] IDX_OVERFLOW   = 8'h07;
  localparam logic [7:0] IDX_MAX_SCAN   = 8'h09;
  localparam logic [7:0] IDX_VSYNC_ST   = 8'h10;
  localparam logic [7:0] IDX_VSYNC_END  = 8'h11;
  localparam logic [7:0] IDX_VDISP_END  = 8'h12;
  localparam logic [7:0] IDX_ROW_OFFSET = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE  = 8'h14;
  localparam logic [7:0] IDX_VBLANK_ST  = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'h17;
  localparam logic [7:0] IDX_PROT_LAST  = 8'h07;

  // ==========================================================
  // field positions
  localparam int PROTECT_BIT    = 7;
  localparam int OVF_LC_BIT     = 4;
  localparam int UL_RSVD_BIT    = 7;
  localparam int UL_DWORD_BIT   = 6;
  localparam int UL_CNT4_BIT    = 5;
  localparam int MC_BYTE_BIT    = 6;
  localparam int MC_WRAP_BIT    = 5;
  localparam int MC_CNT2_BIT    = 3;
  localparam int MS_VBS9_BIT    = 5;

  // ==========================================================
  // reset values and divider last counts
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [9:0] LINE_RESET   = 10'h000;
  localparam logic [1:0] DIV_RESET    = 2'h0;
  localparam logic [1:0] DIV_BY2_LAST = 2'h1;
  localparam logic [1:0] DIV_BY4_LAST = 2'h3;

  // io port selector values
  localparam logic IO_SEL_INDEX = 1'b0;
  localparam logic IO_SEL_DATA  = 1'b1;

  typedef struct packed {
    logic [9:0] vsync_start;
    logic [3:0] vsync_end;
    logic [9:0] vdisp_end;
    logic [9:0] vblank_start;
    logic [7:0] vblank_end;
  } vtiming_t;

  typedef struct packed {
    logic       dword_mode;
    logic       byte_mode;
    logic       wrap_bit15;
    logic       count_by4;
    logic       count_by2;
  } addr_mode_t;

endpackage

// ---- verilog/crtc_vert.sv ----
`timescale 1ns/1ps
module crtc_vert
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // indexed io port: sel 0 = index, 1 = data
  input  wire logic                      io_sel,
  input  wire logic                      io_wr,
  input  wire logic                      io_rd,
  input  wire logic [7:0]                io_wdata,
  output logic      [7:0]                io_rdata_ff,
  // raster timing strobes from the horizontal side
  input  wire logic                      char_tick,
  input  wire logic                      line_tick,
  input  wire logic                      frame_start,
  input  wire logic [4:0]                row_scan,
  input  wire logic                      text_mode,
  input  wire logic                      clocking_mode_dword,
  // vertical timing outputs
  output logic [9:0]                     vline_ff,
  output logic                           vsync_ff,
  output logic                           vblank_ff,
  output logic                           vdisp_ff,
  // address generation outputs
  output logic [15:0]                    fb_addr_ff,
  output logic [9:0]                     row_span_ff,
  output logic                           underline_ff,
  output crtc_vert_pkg::addr_mode_t      addr_mode_ff
);
  import crtc_vert_pkg::*;

  // ==========================================================
  // register storage
  logic [7:0]  index_ff;
  logic [7:0]  overflow_ff;
  logic [7:0]  max_scan_ff;
  logic [7:0]  vsync_start_ff;
  logic [7:0]  vsync_end_ff;
  logic [7:0]  vdisp_end_ff;
  logic [7:0]  row_offset_ff;
  logic [6:0]  underline_loc_ff;
  logic [7:0]  vblank_start_ff;
  logic [7:0]  vblank_end_ff;
  logic [7:0]  mode_ctrl_ff;
  logic [15:0] ma_cnt_ff;
  logic [1:0]  div_ff;

  logic        data_wr;
  logic        protect;
  logic        idx_protected;
  vtiming_t    vt;
  addr_mode_t  am;
  logic [9:0]  nxt_vline;
  logic [1:0]  div_last;
  logic        ma_step;

  // ==========================================================
  // readback mux; unmapped indexes read as zero
  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      IDX_OVERFLOW:   r = overflow_ff;
      IDX_MAX_SCAN:   r = max_scan_ff;
      IDX_VSYNC_ST:   r = vsync_start_ff;
      IDX_VSYNC_END:  r = vsync_end_ff;
      IDX_VDISP_END:  r = vdisp_end_ff;
      IDX_ROW_OFFSET: r = row_offset_ff;
      IDX_UNDERLINE:  r = {1'b0, underline_loc_ff};
      IDX_VBLANK_ST:  r = vblank_start_ff;
      IDX_VBLANK_END: r = vblank_end_ff;
      IDX_MODE_CTRL:  r = mode_ctrl_ff;
      default:        r = 8'h00;
    endcase
    return r;
  endfunction

  // word/dword reorganisation of the counter before the decoder
  function automatic logic [15:0] map_addr(input logic [15:0] ma, input addr_mode_t m);
    logic [15:0] a;
    a = ma;
    if (m.dword_mode)
      a = {ma[13:0], ma[13], ma[12]};
    else if (!m.byte_mode)
      a = {ma[14:0], (m.wrap_bit15 ? ma[15] : ma[13])};
    return a;
  endfunction

  assign data_wr       = io_wr && (io_sel == IO_SEL_DATA);
  assign protect       = vsync_end_ff[PROTECT_BIT];
  assign idx_protected = (index_ff <= IDX_PROT_LAST);

  // ==========================================================
  // index and readback
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      index_ff <= REG_RESET;
    else if (io_wr && (io_sel == IO_SEL_INDEX))
      index_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      io_rdata_ff <= REG_RESET;
    else if (io_rd)
      io_rdata_ff <= (io_sel == IO_SEL_INDEX) ? index_ff : read_reg(index_ff);
  end

  // ==========================================================
  // overflow: the line-compare bit escapes the write protect
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      overflow_ff <= REG_RESET;
    else if (data_wr && (index_ff == IDX_OVERFLOW))
    begin
      if (!protect)
        overflow_ff <= io_wdata;
      else
        overflow_ff[OVF_LC_BIT] <= io_wdata[OVF_LC_BIT];
    end
  end

  // ==========================================================
  // remaining registers, one process each
  // accepted while protected; protect covers only indexes up to IDX_PROT_LAST
  function automatic logic wr_hit(input logic [7:0] idx);
    return data_wr && (index_ff == idx) && !(protect && idx_protected);
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      max_scan_ff <= REG_RESET;
    else if (wr_hit(IDX_MAX_SCAN))
      max_scan_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vsync_start_ff <= REG_RESET;
    else if (wr_hit(IDX_VSYNC_ST))
      vsync_start_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vsync_end_ff <= REG_RESET;
    else if (wr_hit(IDX_VSYNC_END))
      vsync_end_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vdisp_end_ff <= REG_RESET;
    else if (wr_hit(IDX_VDISP_END))
      vdisp_end_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      row_offset_ff <= REG_RESET;
    else if (wr_hit(IDX_ROW_OFFSET))
      row_offset_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      underline_loc_ff <= REG_RESET[6:0];
    else if (wr_hit(IDX_UNDERLINE))
      underline_loc_ff <= io_wdata[6:0];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vblank_start_ff <= REG_RESET;
    else if (wr_hit(IDX_VBLANK_ST))
      vblank_start_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vblank_end_ff <= REG_RESET;
    else if (wr_hit(IDX_VBLANK_END))
      vblank_end_ff <= io_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_ctrl_ff <= REG_RESET;
    else if (wr_hit(IDX_MODE_CTRL))
      mode_ctrl_ff <= io_wdata;
  end

  // ==========================================================
  // assembled timing values
  // ten-bit sync start
  assign vt.vsync_start  = {overflow_ff[7], overflow_ff[2], vsync_start_ff};
  assign vt.vsync_end    = vsync_end_ff[3:0];
  assign vt.vdisp_end    = {overflow_ff[6], overflow_ff[1], vdisp_end_ff};
  assign vt.vblank_start = {max_scan_ff[MS_VBS9_BIT], overflow_ff[3], vblank_start_ff};
  assign vt.vblank_end   = vblank_end_ff;

  assign am.dword_mode = underline_loc_ff[UL_DWORD_BIT];
  assign am.byte_mode  = mode_ctrl_ff[MC_BYTE_BIT];
  assign am.wrap_bit15 = mode_ctrl_ff[MC_WRAP_BIT];
  assign am.count_by4  = underline_loc_ff[UL_CNT4_BIT];
  assign am.count_by2  = mode_ctrl_ff[MC_CNT2_BIT];

  // ==========================================================
  // scan-line counter
  // restart at first active line
  assign nxt_vline = frame_start ? LINE_RESET : 10'(vline_ff + 10'd1);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vline_ff <= LINE_RESET;
    else if (frame_start || line_tick)
      vline_ff <= nxt_vline;
  end

  // sync: start wins when start and end land on the same line
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vsync_ff <= 1'b0;
    else if (frame_start || line_tick)
    begin
      if (nxt_vline == vt.vsync_start)
        vsync_ff <= 1'b1;
      else if (nxt_vline[3:0] == vt.vsync_end)
        vsync_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vblank_ff <= 1'b0;
    else if (frame_start || line_tick)
    begin
      if (nxt_vline == vt.vblank_start)
        vblank_ff <= 1'b1;
      else if (nxt_vline[7:0] == vt.vblank_end)
        vblank_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vdisp_ff <= 1'b0;
    else if (frame_start || line_tick)
      vdisp_ff <= (nxt_vline <= vt.vdisp_end);
  end

  // ==========================================================
  // memory address counter
  // interval select, count-by-2 dominates
  assign div_last = am.count_by2 ? DIV_BY2_LAST : (am.count_by4 ? DIV_BY4_LAST : DIV_RESET);
  assign ma_step  = char_tick && (div_ff == div_last);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_ff <= DIV_RESET;
    else if (frame_start || ma_step)
      div_ff <= DIV_RESET;
    else if (char_tick)
      div_ff <= 2'(div_ff + 2'd1);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ma_cnt_ff <= 16'h0000;
    else if (frame_start)
      ma_cnt_ff <= 16'h0000;
    else if (ma_step)
      ma_cnt_ff <= 16'(ma_cnt_ff + 16'd1);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      fb_addr_ff <= 16'h0000;
    else
      fb_addr_ff <= map_addr(ma_cnt_ff, am);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      row_span_ff <= 10'h000;
    else
      row_span_ff <= clocking_mode_dword ? {row_offset_ff, 2'b00} : {1'b0, row_offset_ff, 1'b0};
  end

  // underline row match in text mode
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      underline_ff <= 1'b0;
    else
      underline_ff <= text_mode && (row_scan == underline_loc_ff[4:0]);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      addr_mode_ff <= '0;
    else
      addr_mode_ff <= am;
  end

endmodule

// ---- verification/crtc_vert_assertions.sv ----
`timescale 1ns/1ps
module crtc_vert_assertions
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // watched ports
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata_ff,
  input wire logic        char_tick,
  input wire logic        line_tick,
  input wire logic        frame_start,
  input wire logic        text_mode,
  input wire logic        clocking_mode_dword,
  input wire logic [9:0]  vline_ff,
  input wire logic        vsync_ff,
  input wire logic        vblank_ff,
  input wire logic        vdisp_ff,
  input wire logic [15:0] fb_addr_ff,
  input wire logic [9:0]  row_span_ff,
  input wire logic        underline_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // vertical raster, address, readback and underline checks
  chk_line_restart: assert property (frame_start |=> (vline_ff == 10'h000) && vdisp_ff)
    else $error("line count not zero after frame start");
  chk_line_step: assert property (line_tick && !frame_start |=> vline_ff == $past(vline_ff) + 10'h001)
    else $error("line count did not step");
  chk_level_hold: assert property (!line_tick && !frame_start |=> $stable(vline_ff) && $stable(vsync_ff)
    && $stable(vblank_ff) && $stable(vdisp_ff))
    else $error("raster level moved without line event");
  chk_sync_cause: assert property ($rose(vsync_ff) |-> $past(line_tick) || $past(frame_start))
    else $error("sync rose without line event");
  chk_read_hold: assert property (!io_rd |=> $stable(io_rdata_ff))
    else $error("read data moved without read");
  chk_addr_hold: assert property ((!char_tick && !frame_start && !io_wr) [*2] |=> $stable(fb_addr_ff))
    else $error("address moved without tick");
  chk_span_even: assert property (row_span_ff[0] == 1'h0 && (!$past(clocking_mode_dword) || row_span_ff[1] == 1'h0))
    else $error("row span not whole words");
  chk_underline_text: assert property (!text_mode |=> !underline_ff)
    else $error("underline outside text mode");
  cover property ($rose(vsync_ff));
  cover property ($fell(vblank_ff));
  cover property (underline_ff);
endmodule
bind crtc_vert crtc_vert_assertions u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
  .io_rdata_ff(io_rdata_ff), .char_tick(char_tick), .line_tick(line_tick), .frame_start(frame_start),
  .text_mode(text_mode), .clocking_mode_dword(clocking_mode_dword), .vline_ff(vline_ff), .vsync_ff(vsync_ff),
  .vblank_ff(vblank_ff), .vdisp_ff(vdisp_ff),
  .fb_addr_ff(fb_addr_ff), .row_span_ff(row_span_ff), .underline_ff(underline_ff));

// ---- verification/crtc_vert_tb_top.sv ----
`timescale 1ns/1ps
module crtc_vert_tb_top;
  import crtc_vert_pkg::*;
  logic        sys_clk, rst_b, io_sel, io_wr, io_rd, char_tick, line_tick, frame_start;
  logic        text_mode, clocking_mode_dword, vsync_ff, vblank_ff, vdisp_ff, underline_ff, vs, vb;
  logic [7:0]  io_wdata, io_rdata_ff;
  logic [4:0]  row_scan;
  logic [9:0]  vline_ff, row_span_ff;
  logic [15:0] fb_addr_ff;
  addr_mode_t  addr_mode_ff;
  int          miscompares, num_checks;
  logic [7:0]  m14 [6] = '{8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h40};
  logic [7:0]  m17 [6] = '{8'h40, 8'h40, 8'h48, 8'h20, 8'h00, 8'h00};
  int          nt  [6] = '{5, 7, 7, 5, 5, 5};
  logic [15:0] ex  [6] = '{16'h0005, 16'h0001, 16'h0003, 16'h000A, 16'h000A, 16'h0014};

  crtc_vert dut (.sys_clk(sys_clk), .rst_b(rst_b), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .char_tick(char_tick), .line_tick(line_tick),
    .frame_start(frame_start), .row_scan(row_scan), .text_mode(text_mode),
    .clocking_mode_dword(clocking_mode_dword), .vline_ff(vline_ff), .vsync_ff(vsync_ff),
    .vblank_ff(vblank_ff), .vdisp_ff(vdisp_ff), .fb_addr_ff(fb_addr_ff), .row_span_ff(row_span_ff),
    .underline_ff(underline_ff), .addr_mode_ff(addr_mode_ff));

  // ==========================================================
  // access and check tasks
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task drive(input logic s, input logic w, input logic r, input logic [7:0] d);
    @(negedge sys_clk);
    io_sel = s;
    io_wr = w;
    io_rd = r;
    io_wdata = d;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    drive(1'h0, 1'h1, 1'h0, a);
    drive(1'h1, 1'h1, 1'h0, d);
    drive(1'h1, 1'h0, 1'h0, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    drive(1'h0, 1'h1, 1'h0, a);
    drive(1'h1, 1'h0, 1'h1, a);
    drive(1'h1, 1'h0, 1'h0, a);
    chk("rdata", {8'h00, io_rdata_ff}, {8'h00, e});
  endtask
  // one event pulse: {frame, line, char}
  task step(input logic [2:0] t);
    @(negedge sys_clk);
    {frame_start, line_tick, char_tick} = t;
    @(negedge sys_clk);
    {frame_start, line_tick, char_tick} = 3'h0;
  endtask
  // vsync end field fixed at 6, blank end at 8
  task run_frame(input logic [9:0] ss, input logic [9:0] bs, input logic [9:0] de);
    logic [9:0] ln;
    for (int l = 0; l < 264; l++)
    begin
      ln = l[9:0];
      step(l == 0 ? 3'h4 : 3'h2);
      vs = (ln == ss) | (vs & (ln[3:0] != 4'h6));
      vb = (ln == bs) | (vb & (ln[7:0] != 8'h08));
      chk("vline", {6'h00, vline_ff}, {6'h00, ln});
      chk("vsync", {15'h0, vsync_ff}, {15'h0, vs});
      chk("vblank", {15'h0, vblank_ff}, {15'h0, vb});
      chk("vdisp", {15'h0, vdisp_ff}, {15'h0, ln <= de});
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end
  initial
  begin
    {rst_b, io_sel, io_wr, io_rd, char_tick, line_tick, frame_start, text_mode, clocking_mode_dword} = '0;
    io_wdata = 8'h00;
    row_scan = 5'h00;
    {vs, vb, miscompares, num_checks} = '0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'h1;
    wr(8'h10, 8'h03);
    wr(8'h11, 8'h06);
    wr(8'h12, 8'h04);
    wr(8'h15, 8'h02);
    wr(8'h16, 8'h08);
    wr(8'h09, 8'h20);
    run_frame(10'h003, 10'h202, 10'h004);
    wr(8'h09, 8'h00);
    wr(8'h07, 8'h0E);
    run_frame(10'h103, 10'h102, 10'h104);
    wr(8'h11, 8'h86);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h1E);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h55);
    wr(8'h11, 8'h36);
    rd(8'h11, 8'h36);
    rd(8'h30, 8'h00);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h7F);
    drive(1'h0, 1'h0, 1'h1, 8'h00);
    drive(1'h0, 1'h0, 1'h0, 8'h00);
    chk("index", {8'h00, io_rdata_ff}, 16'h0014);
    text_mode = 1'h1;
    row_scan = 5'h1F;
    repeat (2) @(negedge sys_clk);
    chk("underline", {15'h0, underline_ff}, 16'h0001);
    row_scan = 5'h1E;
    repeat (2) @(negedge sys_clk);
    chk("underline", {15'h0, underline_ff}, 16'h0000);
    text_mode = 1'h0;
    wr(8'h13, 8'h11);
    @(negedge sys_clk);
    chk("span", {6'h00, row_span_ff}, 16'h0022);
    clocking_mode_dword = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk("span", {6'h00, row_span_ff}, 16'h0044);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h14, m14[i]);
      wr(8'h17, m17[i]);
      step(3'h4);
      repeat (nt[i]) step(3'h1);
      @(negedge sys_clk);
      chk("fb_addr", fb_addr_ff, ex[i]);
      chk("addr_mode", {11'h0, addr_mode_ff}, {11'h0, m14[i][6], m17[i][6], m17[i][5], m14[i][5], m17[i][3]});
    end
    summarize();
  end
endmodule
